// *** hdl/fsc_framed_sync.v ***
// Summary of operation
// - enable bit puts sync pulse on select pin
// - direction bit one receives, zero drives pulse
// - polarity bit sets pulse active level
// - edge select one: pulse with first clock
// - edge select zero: pulse LEAD_CYCLES steps earlier, at least one
// - unused control bits read zero, ignore writes
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "fsc_regs.vh"

module fsc_framed_sync #(
    parameter LEAD_CYCLES = 1
) (
    // clock and reset
    input wire CLK,
    input wire RST_N,
    input wire CE,
    // register port
    input wire [`FSC_ADDR_W-1:0] ADDR,
    input wire [`FSC_DATA_W-1:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [`FSC_DATA_W-1:0] RDATA,
    // frame request from the shifter
    input wire FRAME_START,
    output reg FIRST_BIT_CLK,
    // select pin
    input wire SYNC_PIN_IN,
    output reg SYNC_PIN_OUT,
    output reg SYNC_PIN_OE_N,
    // received frame start
    output reg FRAME_SYNC_DET
);

// ----------------------------------------
// local constants
// ----------------------------------------
// full width first, so the cut to the counter width is deliberate
localparam [31:0] LEAD_FULL = LEAD_CYCLES;
localparam [`FSC_CNT_W-1:0] LEAD_INIT = LEAD_FULL[`FSC_CNT_W-1:0];

// ----------------------------------------
// register address decode
// ----------------------------------------
reg wr_ctrl;
reg rd_ctrl;
reg rd_stat;

// unmapped addresses decode to nothing: writes dropped, reads zero
// strobes meet the clock enable in the registers, not here
always @* begin
    wr_ctrl = 1'b0;
    rd_ctrl = 1'b0;
    rd_stat = 1'b0;
    if (ADDR == `FSC_CTRL_ADDR) begin
        wr_ctrl = WR;
        rd_ctrl = RD;
    end else if (ADDR == `FSC_STAT_ADDR) begin
        rd_stat = RD;
    end
end

// ----------------------------------------
// control register
// ----------------------------------------
reg [`FSC_DATA_W-1:0] framed_serial_control;

// unimplemented positions are never stored
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        framed_serial_control <= `FSC_CTRL_RESET;
    end else if (CE && wr_ctrl) begin
        framed_serial_control <= WDATA & `FSC_CTRL_MASK;
    end
end

// ----------------------------------------
// control fields
// ----------------------------------------
wire framed_mode_enable = framed_serial_control[`FSC_BIT_ENABLE];
wire sync_pulse_direction = framed_serial_control[`FSC_BIT_DIR];
wire sync_pulse_polarity = framed_serial_control[`FSC_BIT_POL];
wire sync_pulse_edge_select = framed_serial_control[`FSC_BIT_EDGE];

// ----------------------------------------
// operating mode
// ----------------------------------------
wire master = framed_mode_enable && !sync_pulse_direction;
wire slave = framed_mode_enable && sync_pulse_direction;

// ----------------------------------------
// pin input synchroniser
// ----------------------------------------
reg sync_meta;
reg sync_pin;
reg sync_pin_d;

// first stage may go metastable; only the second stage reads it
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        sync_meta <= 1'b0;
    end else if (CE) begin
        sync_meta <= SYNC_PIN_IN;
    end
end

always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        sync_pin <= 1'b0;
    end else if (CE) begin
        sync_pin <= sync_meta;
    end
end

// edge history, taken from the settled stage
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        sync_pin_d <= 1'b0;
    end else if (CE) begin
        sync_pin_d <= sync_pin;
    end
end

// active level folded in so both polarities look active-high
wire sync_active = sync_pulse_polarity ? sync_pin : ~sync_pin;
wire sync_active_d = sync_pulse_polarity ? sync_pin_d : ~sync_pin_d;
wire slave_edge = slave && sync_active && !sync_active_d;

// ----------------------------------------
// master pulse sequencer
// ----------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_LEAD = 2'h1;
localparam ST_FIRST = 2'h2;

reg [1:0] state;
reg [1:0] next_state;
reg [`FSC_CNT_W-1:0] lead_cnt;
reg [`FSC_CNT_W-1:0] next_lead_cnt;
reg pulse_on;
reg first_clk;
reg pulse_seen;

// leaving master mode aborts a frame at once
// a frame start while busy or outside master mode is dropped
// a lead count of zero still gives one lead cycle
always @* begin
    next_state = state;
    next_lead_cnt = lead_cnt;
    case (state)
        ST_IDLE: begin
            if (FRAME_START) begin
                if (sync_pulse_edge_select) begin
                    next_state = ST_FIRST;
                end else begin
                    next_state = ST_LEAD;
                    next_lead_cnt = LEAD_INIT;
                end
            end
        end
        ST_LEAD: begin
            if (lead_cnt <= `FSC_CNT_ONE) begin
                next_state = ST_FIRST;
            end else begin
                next_lead_cnt = lead_cnt - `FSC_CNT_ONE;
            end
        end
        ST_FIRST: begin
            next_state = ST_IDLE;
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
    if (!master) begin
        next_state = ST_IDLE;
    end
end

// pin and marker decode of the sequencer state
always @* begin
    pulse_on = 1'b0;
    first_clk = 1'b0;
    case (state)
        ST_LEAD: begin
            // pulse alone, ahead of the first bit clock
            pulse_on = 1'b1;
        end
        ST_FIRST: begin
            first_clk = 1'b1;
            // coincident mode holds the pulse through the first clock
            pulse_on = sync_pulse_edge_select;
        end
        default: begin
            pulse_on = 1'b0;
        end
    endcase
end

always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        state <= ST_IDLE;
        lead_cnt <= `FSC_CNT_ZERO;
    end else if (CE) begin
        state <= next_state;
        lead_cnt <= next_lead_cnt;
    end
end

// ----------------------------------------
// select pin drive
// ----------------------------------------
// pin drive is registered, so it follows the state by one cycle
// slave mode and disabled mode release the pin
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        SYNC_PIN_OE_N <= 1'b1;
    end else if (CE) begin
        SYNC_PIN_OE_N <= !master;
    end
end

// idle level tracks polarity, so a polarity change moves the pin at once
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        SYNC_PIN_OUT <= 1'b1;
    end else if (CE) begin
        SYNC_PIN_OUT <= pulse_on ~^ sync_pulse_polarity;
    end
end

// ----------------------------------------
// frame markers
// ----------------------------------------
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        FIRST_BIT_CLK <= 1'b0;
    end else if (CE) begin
        FIRST_BIT_CLK <= first_clk;
    end
end

// slave: rising edge of the active level marks a frame
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        FRAME_SYNC_DET <= 1'b0;
    end else if (CE) begin
        FRAME_SYNC_DET <= slave_edge;
    end
end

// ----------------------------------------
// status register
// ----------------------------------------
// a pulse landing with the clearing read wins, so none is lost
always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        pulse_seen <= 1'b0;
    end else if (CE) begin
        if (slave_edge) begin
            pulse_seen <= 1'b1;
        end else if (rd_stat) begin
            pulse_seen <= 1'b0;
        end
    end
end

// snapshot only; positions above the flags read zero
reg [`FSC_DATA_W-1:0] status_word;
always @* begin
    status_word = `FSC_RDATA_IDLE;
    status_word[`FSC_ST_SYNC_IN] = sync_active;
    status_word[`FSC_ST_PULSE_SEEN] = pulse_seen;
    status_word[`FSC_ST_BUSY] = (state != ST_IDLE);
    status_word[`FSC_ST_FRAME_PHASE] = (state == ST_LEAD);
end

// ----------------------------------------
// read data
// ----------------------------------------
reg [`FSC_DATA_W-1:0] next_rdata;

// data stand one cycle only; zero otherwise lets ports be or-ed
always @* begin
    if (rd_ctrl) begin
        next_rdata = framed_serial_control & `FSC_CTRL_MASK;
    end else if (rd_stat) begin
        next_rdata = status_word;
    end else begin
        next_rdata = `FSC_RDATA_IDLE;
    end
end

always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
        RDATA <= `FSC_RDATA_IDLE;
    end else if (CE) begin
        RDATA <= next_rdata;
    end
end

endmodule

// *** hdl/fsc_regs.vh ***
`ifndef FSC_REGS_VH
`define FSC_REGS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define FSC_ADDR_W 4
`define FSC_CTRL_ADDR 4'h0
`define FSC_STAT_ADDR 4'h1
`define FSC_DATA_W 16
`define FSC_CTRL_RESET 16'h0000
`define FSC_CTRL_MASK 16'hE002
`define FSC_RDATA_IDLE 16'h0000
// ----------------------------------------
// sequencer timing
// ----------------------------------------
`define FSC_CNT_W 8
`define FSC_CNT_ONE 8'h01
`define FSC_CNT_ZERO 8'h00
// ----------------------------------------
// control fields
// ----------------------------------------
`define FSC_BIT_ENABLE 15
`define FSC_BIT_DIR 14
`define FSC_BIT_POL 13
`define FSC_BIT_EDGE 1
// ----------------------------------------
// status fields
// ----------------------------------------
`define FSC_ST_SYNC_IN 0
`define FSC_ST_PULSE_SEEN 1
`define FSC_ST_BUSY 2
`define FSC_ST_FRAME_PHASE 3
`endif

// *** tb/fsc_framed_sync_properties.sv ***
`timescale 1ns/10ps
module fsc_chk (
    // clock and reset
    input wire CLK,
    input wire RST_N,
    input wire CE,
    // bus
    input wire WR,
    input wire RD,
    input wire [3:0] ADDR,
    input wire [15:0] WDATA,
    input wire [15:0] RDATA,
    // pins
    input wire FRAME_START,
    input wire FIRST_BIT_CLK,
    input wire SYNC_PIN_IN,
    input wire SYNC_PIN_OUT,
    input wire SYNC_PIN_OE_N,
    input wire FRAME_SYNC_DET
);
    reg [15:0] c;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) c <= 16'h0000;
        else if (CE && WR && ADDR == 4'h0) c <= WDATA;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // enable lags the control write by one cycle, hence the stable guard
    property p_oe; $stable(c) |-> SYNC_PIN_OE_N == !(c[15] && !c[14]); endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_first; FIRST_BIT_CLK |-> c[15] && !c[14]; endproperty
    a_first: assert property (p_first) else $error("frame started outside master");
    property p_slave; FRAME_SYNC_DET |-> $past(SYNC_PIN_IN, 3) == c[13]
        && $past(SYNC_PIN_IN, 4) != c[13]; endproperty
    a_slave: assert property (p_slave) else $error("sync detect wrong");
    property p_with; FIRST_BIT_CLK && c[1] |-> SYNC_PIN_OUT == c[13] && $past(FRAME_START, 2);
    endproperty
    a_with: assert property (p_with) else $error("pulse not with first clock");
    property p_lead; FIRST_BIT_CLK && !c[1] |-> SYNC_PIN_OUT != c[13]
        && $past(SYNC_PIN_OUT) == c[13]; endproperty
    a_lead: assert property (p_lead) else $error("pulse not ahead");
    property p_rd; CE && RD && ADDR == 4'h0 |=> RDATA == ($past(c) & 16'hE002); endproperty
    a_rd: assert property (p_rd) else $error("control readback wrong");
    property p_det; CE && FRAME_SYNC_DET |=> !FRAME_SYNC_DET; endproperty
    a_det: assert property (p_det) else $error("sync detect too long");
endmodule
bind fsc_framed_sync fsc_chk u_chk (.*);

// *** tb/fsc_peer.sv ***
`timescale 1ns/10ps
module fsc_peer (
    // link side
    input wire clk,
    input wire go,
    input wire pol,
    output reg pin
);
    initial pin = 1'b1;
    // drives every cycle: the chosen active level while go is high, the other level otherwise
    always @(posedge clk) pin <= go ? pol : !pol;
endmodule

// *** tb/fsc_framed_sync_tb.sv ***
`timescale 1ns/10ps
module fsc_framed_sync_tb;
    reg CLK = 0, RST_N = 0, CE = 1, WR = 0, RD = 0, FRAME_START = 0, go = 0, pol = 0;
    reg [3:0] ADDR = 4'h0;
    reg [15:0] WDATA = 16'h0000;
    wire [15:0] RDATA;
    wire FIRST_BIT_CLK, SYNC_PIN_OUT, SYNC_PIN_OE_N, FRAME_SYNC_DET, peer_pin;
    wire pin = SYNC_PIN_OE_N ? peer_pin : SYNC_PIN_OUT;
    integer n_errors = 0, total_checks = 0, i, k;
    fsc_framed_sync dut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .FRAME_START(FRAME_START),
        .FIRST_BIT_CLK(FIRST_BIT_CLK), .SYNC_PIN_IN(pin), .SYNC_PIN_OUT(SYNC_PIN_OUT),
        .SYNC_PIN_OE_N(SYNC_PIN_OE_N), .FRAME_SYNC_DET(FRAME_SYNC_DET));
    fsc_peer peer (.clk(CLK), .go(go), .pol(pol), .pin(peer_pin));
    initial forever #5 CLK = ~CLK;
    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge CLK); ADDR <= a; WDATA <= d; WR <= 1'b1;
            @(posedge CLK); WR <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [15:0] e);
        begin
            @(posedge CLK); ADDR <= a; RD <= 1'b1;
            @(posedge CLK); RD <= 1'b0;
            #1 chk(RDATA, e);
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        #100000 n_errors = n_errors + 1;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        rd(4'h0, 16'h0000);
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'hE002);
        @(posedge CLK); CE <= 1'b0;
        wr(4'h0, 16'h0000);
        @(posedge CLK); CE <= 1'b1;
        rd(4'h0, 16'hE002);
        rd(4'hF, 16'h0000);
        @(posedge CLK); #1 chk(RDATA, 16'h0000);
        // master: every polarity and edge select
        for (i = 0; i < 4; i = i + 1) begin
            pol = i[1];
            wr(4'h0, {2'b10, pol, 11'h000, i[0], 1'b0});
            repeat (3) @(posedge CLK);
            #1 chk(SYNC_PIN_OUT, !pol);
            chk(SYNC_PIN_OE_N, 0);
            @(posedge CLK); FRAME_START <= 1'b1;
            @(posedge CLK); FRAME_START <= 1'b0;
            #1 k = 0;
            while (FIRST_BIT_CLK !== 1'b1 && k < 9) begin @(posedge CLK); #1 k = k + 1; end
            if (k >= 9) begin n_errors = n_errors + 1; give_verdict; end
            chk(k, 2 - i[0]);
            chk(SYNC_PIN_OUT, i[0] ? pol : !pol);
        end
        // slave: start requests must be refused meanwhile
        for (i = 0; i < 2; i = i + 1) begin
            pol = i[0];
            wr(4'h0, {2'b11, pol, 13'h0000});
            repeat (4) @(posedge CLK);
            #1 chk(SYNC_PIN_OE_N, 1);
            @(posedge CLK); go <= 1'b1; FRAME_START <= 1'b1;
            #1 k = 0;
            while (FRAME_SYNC_DET !== 1'b1 && k < 9) begin @(posedge CLK); #1 k = k + 1; end
            if (k >= 9) begin n_errors = n_errors + 1; give_verdict; end
            chk(k, 4);
            chk(FIRST_BIT_CLK, 0);
            rd(4'h1, 16'h0003);
            rd(4'h1, 16'h0001);
            @(posedge CLK); go <= 1'b0; FRAME_START <= 1'b0;
        end
        wr(4'h0, 16'h0000);
        repeat (3) @(posedge CLK);
        #1 chk(SYNC_PIN_OE_N, 1);
        give_verdict;
    end
endmodule
